// ---- plsf_pkg.sv ----
// constants, field layout and state type of the pll source select block
// *********************************************************************
// Operation
// RULE_01: Limit flag is high while count exceeds 4-bit threshold, reset 0.
// RULE_02: Divider off bit lets feedback divider run at 0, stops it at 1.
// RULE_03: Software stops the divider only with external feedback selected; the code also takes a stop on internal feedback and sets fb_config_conflict.
// RULE_04: Feedback source 0 is the multi-modulus divider, 1 is input a.
// RULE_05: An own output fed back needs disable group 0x7 unless startup 0x2.
// RULE_06: Reference select: crystal, input a, input b, or ground for none.
// RULE_07: Bit 31 gates the crystal clock into the bank 5 mux, reset enabled.
// RULE_08: Bits 30..28 gate input b into banks 6..4, each reset enabled.
// RULE_09: Auto fanout mode 2: the mux drives the input b gate, writes ignored.
// RULE_10: Bits 27..25 gate input a into banks 6..4, each reset enabled.
// RULE_11: Auto fanout mode 1: the mux drives the input a gate, writes ignored.
// RULE_12: A read of a hardware-driven gate returns the applied value.
// *********************************************************************
package plsf_pkg;

   localparam int CFG_W      = 8;
   localparam int BANK_W     = 32;
   localparam int IDX_W      = 2;
   localparam int THR_W      = 4;
   localparam int MODE_W     = 3;
   localparam int AUTO_BANKS = 3;

   // register indices on the register port
   localparam logic [IDX_W-1:0] IDX_REF_FB  = 2'h0;
   localparam logic [IDX_W-1:0] IDX_BANK_EN = 2'h1;

   // reset values
   localparam logic [CFG_W-1:0]  CFG_RESET  = 8'h00;
   localparam logic [BANK_W-1:0] BANK_RESET = 32'hffffffff;
   localparam logic [2:0]        PICK_RESET = 3'h1;

   // reference and feedback configuration fields
   localparam int THR_HI    = 7;
   localparam int THR_LO    = 4;
   localparam int FBOFF_BIT = 3;
   localparam int FBSEL_BIT = 2;
   localparam int REF_HI    = 1;
   localparam int REF_LO    = 0;

   // bank mux enable fields
   localparam int XTAL_B5_BIT = 31;
   localparam int B_GATE_LO   = 28;
   localparam int A_GATE_LO   = 25;

   // reference choices
   localparam logic [1:0] REF_XTAL = 2'h0;
   localparam logic [1:0] REF_IN_A = 2'h1;
   localparam logic [1:0] REF_IN_B = 2'h2;
   localparam logic [1:0] REF_NONE = 2'h3;

   // one-hot reference picks, all low for ground
   localparam logic [2:0] PICK_XTAL = 3'h1;
   localparam logic [2:0] PICK_IN_A = 3'h2;
   localparam logic [2:0] PICK_IN_B = 3'h4;
   localparam logic [2:0] PICK_NONE = 3'h0;

   // fanout source modes that hand a gate to hardware
   localparam logic [MODE_W-1:0] MODE_INPUT_A = 3'h1;
   localparam logic [MODE_W-1:0] MODE_INPUT_B = 3'h2;

   typedef struct packed {
      logic [BANK_W-1:0] rdata;
      logic [BANK_W-1:0] bank_en;
      logic [CFG_W-1:0]  cfg;
      logic [2:0]        ref_pick;
      logic              limit;
      logic              conflict;
   } plsf_state_t;

endpackage

// ---- plsf_top.sv ----
// pll reference/feedback selection, unlock limit and bank mux gates
`timescale 1ns/1ns
module plsf_top #(
   parameter int LOL_CNT_W = 8
) (
   input  wire logic                             clk,              // 25 MHz
   input  wire logic                             sys_rst,          // async
   input  wire logic                             reg_wr,           // write
   input  wire logic                             reg_rd,           // read
   input  wire logic [plsf_pkg::IDX_W-1:0]       reg_idx,          // index
   input  wire logic [plsf_pkg::BANK_W-1:0]      reg_wdata,        // data
   output      logic [plsf_pkg::BANK_W-1:0]      reg_rdata,        // read
   input  wire logic [LOL_CNT_W-1:0]             lol_count,        // count
   input  wire logic [plsf_pkg::AUTO_BANKS-1:0]  bank_auto_fanout, // 4..6
   input  wire logic [plsf_pkg::AUTO_BANKS*plsf_pkg::MODE_W-1:0]
                                                 bank_fanout_mode, // mode
   input  wire logic [plsf_pkg::AUTO_BANKS-1:0]  mux_uses_input_a, // sel a
   input  wire logic [plsf_pkg::AUTO_BANKS-1:0]  mux_uses_input_b, // sel b
   output      logic                             unlock_limit,     // flag
   output      logic [plsf_pkg::THR_W-1:0]       unlock_count_threshold,
   output      logic                             feedback_divider_off,
   output      logic                             feedback_source_select,
   output      logic [1:0]                       ref_select,       // field
   output      logic [2:0]                       ref_pick,         // 1-hot
   output      logic                             fb_config_conflict,
   output      logic [plsf_pkg::BANK_W-1:0]      bank_mux_enables  // gates
);
   import plsf_pkg::*;

   // *****************************************************************
   // hardware takeover of bank 4..6 gates
   // *****************************************************************
   logic [AUTO_BANKS-1:0] auto_a;
   logic [AUTO_BANKS-1:0] auto_b;
   logic [BANK_W-1:0]     hw_mask;
   logic [BANK_W-1:0]     hw_val;

   genvar gi;
   generate
      for (gi = 0; gi < AUTO_BANKS; gi++) begin : g_bank
         assign auto_a[gi] = bank_auto_fanout[gi] &&
            (bank_fanout_mode[gi*MODE_W +: MODE_W] == MODE_INPUT_A); // RULE_11
         assign auto_b[gi] = bank_auto_fanout[gi] &&
            (bank_fanout_mode[gi*MODE_W +: MODE_W] == MODE_INPUT_B); // RULE_09
      end
   endgenerate

   // bank 4+i sits at bit LO+i, so the per-bank vectors shift straight in
   assign hw_mask = (BANK_W'(auto_b) << B_GATE_LO) |
                    (BANK_W'(auto_a) << A_GATE_LO);
   assign hw_val  = (BANK_W'(mux_uses_input_b) << B_GATE_LO) |
                    (BANK_W'(mux_uses_input_a) << A_GATE_LO);

   // *****************************************************************
   // state update
   // *****************************************************************
   plsf_state_t st_reg;
   plsf_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (reg_wr && reg_idx == IDX_REF_FB) begin
         st_next.cfg = reg_wdata[CFG_W-1:0]; // RULE_02 RULE_04 RULE_06
      end
      if (reg_wr && reg_idx == IDX_BANK_EN) begin
         st_next.bank_en = reg_wdata; // RULE_07 RULE_08 RULE_10
      end
      // hardware wins over a write on a taken-over gate
      st_next.bank_en = (st_next.bank_en & ~hw_mask) |
                        (hw_val & hw_mask); // RULE_09 RULE_11
      st_next.limit = lol_count >
         LOL_CNT_W'(st_reg.cfg[THR_HI:THR_LO]); // RULE_01
      case (st_next.cfg[REF_HI:REF_LO]) // RULE_06
         REF_XTAL: begin
            st_next.ref_pick = PICK_XTAL;
         end
         REF_IN_A: begin
            st_next.ref_pick = PICK_IN_A;
         end
         REF_IN_B: begin
            st_next.ref_pick = PICK_IN_B;
         end
         default: begin
            st_next.ref_pick = PICK_NONE;
         end
      endcase
      // a stopped divider on internal feedback leaves the loop open
      st_next.conflict = st_next.cfg[FBOFF_BIT] &&
                         !st_next.cfg[FBSEL_BIT];
      if (reg_rd) begin
         case (reg_idx)
            IDX_REF_FB: begin
               st_next.rdata = BANK_W'(st_reg.cfg);
            end
            IDX_BANK_EN: begin
               st_next.rdata = st_reg.bank_en; // RULE_12
            end
            default: begin
               st_next.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg.rdata    <= '0;
         st_reg.bank_en  <= BANK_RESET;
         st_reg.cfg      <= CFG_RESET;
         st_reg.ref_pick <= PICK_RESET;
         st_reg.limit    <= 1'b0;
         st_reg.conflict <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // *****************************************************************
   // outputs
   // *****************************************************************
   assign reg_rdata              = st_reg.rdata;
   assign unlock_limit           = st_reg.limit;
   assign unlock_count_threshold = st_reg.cfg[THR_HI:THR_LO];
   assign feedback_divider_off   = st_reg.cfg[FBOFF_BIT]; // RULE_02
   assign feedback_source_select = st_reg.cfg[FBSEL_BIT]; // RULE_04
   assign ref_select             = st_reg.cfg[REF_HI:REF_LO];
   assign ref_pick               = st_reg.ref_pick;
   assign fb_config_conflict     = st_reg.conflict;
   assign bank_mux_enables       = st_reg.bank_en;

   // *****************************************************************
   // assertions
   // *****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   logic wr_cfg;
   logic wr_bank;
   assign wr_cfg  = reg_wr && reg_idx == IDX_REF_FB;
   assign wr_bank = reg_wr && reg_idx == IDX_BANK_EN;

   AST_LIMIT_SET: assert property ( // RULE_01
      (lol_count > LOL_CNT_W'(unlock_count_threshold)) |=> unlock_limit)
      else $error("unlock limit not raised");

   AST_LIMIT_CLR: assert property ( // RULE_01
      (lol_count <= LOL_CNT_W'(unlock_count_threshold)) |=> !unlock_limit)
      else $error("unlock limit raised without cause");

   AST_FBDIV_WR: assert property ( // RULE_02
      wr_cfg |=> feedback_divider_off == $past(reg_wdata[FBOFF_BIT]))
      else $error("divider off bit not taken");

   AST_FBSEL_WR: assert property ( // RULE_04
      wr_cfg ##1 !wr_cfg |=>
         feedback_source_select == $past(reg_wdata[FBSEL_BIT], 2))
      else $error("feedback source not held");

   AST_REF_NONE: assert property ( // RULE_06
      (wr_cfg && reg_wdata[REF_HI:REF_LO] == REF_NONE) |=>
         (ref_pick == PICK_NONE && ref_select == REF_NONE))
      else $error("ground reference still picks a clock");

   AST_REF_A: assert property ( // RULE_06
      (wr_cfg && reg_wdata[REF_HI:REF_LO] == REF_IN_A) |=>
         ref_pick == PICK_IN_A)
      else $error("input a not picked as reference");

   AST_XTAL_WR: assert property ( // RULE_07
      wr_bank |=> bank_mux_enables[XTAL_B5_BIT] ==
         $past(reg_wdata[XTAL_B5_BIT]))
      else $error("crystal gate write lost");

   AST_B_MANUAL: assert property ( // RULE_08
      (wr_bank && !auto_b[2]) |=>
         bank_mux_enables[B_GATE_LO+2] == $past(reg_wdata[B_GATE_LO+2]))
      else $error("input b gate of bank 6 write lost");

   AST_B_AUTO: assert property ( // RULE_09
      auto_b[0] |=> bank_mux_enables[B_GATE_LO] ==
         $past(mux_uses_input_b[0]))
      else $error("input b gate of bank 4 not driven by hardware");

   AST_A_MANUAL: assert property ( // RULE_10
      (wr_bank && !auto_a[1]) |=>
         bank_mux_enables[A_GATE_LO+1] == $past(reg_wdata[A_GATE_LO+1]))
      else $error("input a gate of bank 5 write lost");

   AST_A_AUTO: assert property ( // RULE_11
      auto_a[2] |=> bank_mux_enables[A_GATE_LO+2] ==
         $past(mux_uses_input_a[2]))
      else $error("input a gate of bank 6 not driven by hardware");

   AST_READBACK: assert property ( // RULE_12
      (auto_a[0] && $past(auto_a[0]) && reg_rd && reg_idx == IDX_BANK_EN)
         |=> reg_rdata[A_GATE_LO] == $past(mux_uses_input_a[0], 2))
      else $error("read does not show applied gate");

   // *****************************************************************
   // hold, reference, readback and per-bank checks
   // *****************************************************************
   // the hold checks catch a field or gate that moves without a write,
   // which the write checks above would never see

   AST_FBDIV_HOLD: assert property ( // RULE_02
      !wr_cfg |=> $stable(feedback_divider_off))
      else $error("divider off bit moved without a write");

   AST_FBSEL_HOLD: assert property ( // RULE_04
      !wr_cfg |=> $stable(feedback_source_select))
      else $error("feedback source moved without a write");

   AST_REF_XTAL: assert property ( // RULE_06
      (wr_cfg && reg_wdata[REF_HI:REF_LO] == REF_XTAL) |=>
         ref_pick == PICK_XTAL)
      else $error("crystal not picked as reference");

   AST_REF_B: assert property ( // RULE_06
      (wr_cfg && reg_wdata[REF_HI:REF_LO] == REF_IN_B) |=>
         ref_pick == PICK_IN_B)
      else $error("input b not picked as reference");

   AST_THR_RD: assert property ( // RULE_01
      (reg_rd && reg_idx == IDX_REF_FB) |=>
         reg_rdata[THR_HI:THR_LO] == $past(unlock_count_threshold))
      else $error("threshold read back wrong");

   AST_RD_HOLD: assert property ( // RULE_12
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");

   AST_XTAL_HOLD: assert property ( // RULE_07
      !wr_bank |=> $stable(bank_mux_enables[XTAL_B5_BIT]))
      else $error("crystal gate moved without a write");

   AST_B4_MANUAL: assert property ( // RULE_08
      (wr_bank && !auto_b[0]) |=>
         bank_mux_enables[B_GATE_LO] == $past(reg_wdata[B_GATE_LO]))
      else $error("input b gate of bank 4 write lost");

   AST_B5_MANUAL: assert property ( // RULE_08
      (wr_bank && !auto_b[1]) |=>
         bank_mux_enables[B_GATE_LO+1] == $past(reg_wdata[B_GATE_LO+1]))
      else $error("input b gate of bank 5 write lost");

   AST_B4_HOLD: assert property ( // RULE_08
      (!wr_bank && !auto_b[0]) |=> $stable(bank_mux_enables[B_GATE_LO]))
      else $error("input b gate of bank 4 moved on its own");

   AST_B6_HOLD: assert property ( // RULE_08
      (!wr_bank && !auto_b[2]) |=> $stable(bank_mux_enables[B_GATE_LO+2]))
      else $error("input b gate of bank 6 moved on its own");

   AST_B5_AUTO: assert property ( // RULE_09
      auto_b[1] |=> bank_mux_enables[B_GATE_LO+1] ==
         $past(mux_uses_input_b[1]))
      else $error("input b gate of bank 5 not driven by hardware");

   AST_B6_AUTO: assert property ( // RULE_09
      auto_b[2] |=> bank_mux_enables[B_GATE_LO+2] ==
         $past(mux_uses_input_b[2]))
      else $error("input b gate of bank 6 not driven by hardware");

   AST_A4_MANUAL: assert property ( // RULE_10
      (wr_bank && !auto_a[0]) |=>
         bank_mux_enables[A_GATE_LO] == $past(reg_wdata[A_GATE_LO]))
      else $error("input a gate of bank 4 write lost");

   AST_A6_MANUAL: assert property ( // RULE_10
      (wr_bank && !auto_a[2]) |=>
         bank_mux_enables[A_GATE_LO+2] == $past(reg_wdata[A_GATE_LO+2]))
      else $error("input a gate of bank 6 write lost");

   AST_A4_HOLD: assert property ( // RULE_10
      (!wr_bank && !auto_a[0]) |=> $stable(bank_mux_enables[A_GATE_LO]))
      else $error("input a gate of bank 4 moved on its own");

   AST_A6_HOLD: assert property ( // RULE_10
      (!wr_bank && !auto_a[2]) |=> $stable(bank_mux_enables[A_GATE_LO+2]))
      else $error("input a gate of bank 6 moved on its own");

   AST_A4_AUTO: assert property ( // RULE_11
      auto_a[0] |=> bank_mux_enables[A_GATE_LO] ==
         $past(mux_uses_input_a[0]))
      else $error("input a gate of bank 4 not driven by hardware");

   AST_A5_AUTO: assert property ( // RULE_11
      auto_a[1] |=> bank_mux_enables[A_GATE_LO+1] ==
         $past(mux_uses_input_a[1]))
      else $error("input a gate of bank 5 not driven by hardware");

   // *****************************************************************
   // covers
   // *****************************************************************
   COV_LIMIT: cover property (
      !unlock_limit ##1 unlock_limit ##[1:8] !unlock_limit);
   COV_AUTO_OVERRIDE: cover property (
      wr_bank && auto_b[1] && reg_wdata[B_GATE_LO+1] != mux_uses_input_b[1]);
   COV_ZERO_DELAY: cover property (
      feedback_source_select && feedback_divider_off);
   COV_NO_REF: cover property (ref_pick == PICK_NONE);
   COV_AUTO_READ: cover property (
      reg_rd && reg_idx == IDX_BANK_EN && auto_a[0]);

endmodule

// ---- plsf_top_tb.sv ----
// self-checking testbench for the pll source select block
`timescale 1ns/1ns
module plsf_top_tb;
   import plsf_pkg::*;

   // *********************************************
   // signals
   // *********************************************
   logic                          clk;
   logic                          sys_rst;
   logic                          reg_wr;
   logic                          reg_rd;
   logic [IDX_W-1:0]              reg_idx;
   logic [BANK_W-1:0]             reg_wdata;
   logic [BANK_W-1:0]             reg_rdata;
   logic [7:0]                    lol_count;
   logic [AUTO_BANKS-1:0]         bank_auto_fanout;
   logic [AUTO_BANKS*MODE_W-1:0]  bank_fanout_mode;
   logic [AUTO_BANKS-1:0]         mux_uses_input_a;
   logic [AUTO_BANKS-1:0]         mux_uses_input_b;
   logic                          unlock_limit;
   logic [THR_W-1:0]              unlock_count_threshold;
   logic                          feedback_divider_off;
   logic                          feedback_source_select;
   logic [1:0]                    ref_select;
   logic [2:0]                    ref_pick;
   logic                          fb_config_conflict;
   logic [BANK_W-1:0]             bank_mux_enables;
   int                            n_errors;
   int                            checks;

   plsf_top #(.LOL_CNT_W(8)) dut (.clk(clk), .sys_rst(sys_rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lol_count(lol_count),
      .bank_auto_fanout(bank_auto_fanout),
      .bank_fanout_mode(bank_fanout_mode),
      .mux_uses_input_a(mux_uses_input_a),
      .mux_uses_input_b(mux_uses_input_b), .unlock_limit(unlock_limit),
      .unlock_count_threshold(unlock_count_threshold),
      .feedback_divider_off(feedback_divider_off),
      .feedback_source_select(feedback_source_select),
      .ref_select(ref_select), .ref_pick(ref_pick),
      .fb_config_conflict(fb_config_conflict),
      .bank_mux_enables(bank_mux_enables));

   // *********************************************
   // tasks
   // *********************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one idle cycle after each access keeps the strobe edges apart
   task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d);
      reg_idx = i;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
      cyc(1);
   endtask

   task automatic rd(input logic [IDX_W-1:0] i, input logic [31:0] exp);
      reg_idx = i;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
      cyc(1);
   endtask

   task automatic test_done;
      if (n_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // watchdog: the tests need well under a thousand cycles
   initial begin
      #400000;
      n_errors++;
      test_done();
   end

   // *********************************************
   // tests
   // *********************************************
   initial begin
      n_errors = 0;
      checks = 0;
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_idx = 2'h0;
      reg_wdata = 32'h0;
      lol_count = 8'h00;
      bank_auto_fanout = 3'h0;
      bank_fanout_mode = 9'h000;
      mux_uses_input_a = 3'h0;
      mux_uses_input_b = 3'h0;
      repeat (3) @(posedge clk);
      #1 sys_rst = 1'b0;
      cyc(1);
      chk({31'h0, unlock_limit}, 32'h0);
      rd(IDX_REF_FB, 32'h0);
      rd(IDX_BANK_EN, 32'hffffffff);
      chk({29'h0, ref_pick}, 32'h1);
      lol_count = 8'h01;
      cyc(1);
      chk({31'h0, unlock_limit}, 32'h1);
      for (int r = 0; r < 4; r++) begin
         wr(IDX_REF_FB, 32'(r));
         chk({30'h0, ref_select}, 32'(r));
         chk({29'h0, ref_pick}, r == 3 ? 32'h0 : 32'h1 << r);
      end
      // divider stopped on external feedback from input a, then on internal feedback,
      // which raises the conflict flag; no own output is fed back, so no disable group needs setting
      wr(IDX_REF_FB, 32'h0c);
      chk({31'h0, feedback_divider_off}, 32'h1);
      chk({31'h0, feedback_source_select}, 32'h1);
      chk({31'h0, fb_config_conflict}, 32'h0);
      wr(IDX_REF_FB, 32'h08);
      chk({31'h0, feedback_divider_off}, 32'h1);
      chk({31'h0, feedback_source_select}, 32'h0);
      chk({31'h0, fb_config_conflict}, 32'h1);
      wr(IDX_REF_FB, 32'h00);
      chk({31'h0, feedback_divider_off}, 32'h0);
      lol_count = 8'h05;
      wr(IDX_REF_FB, 32'h50);
      chk({31'h0, unlock_limit}, 32'h0);
      lol_count = 8'h06;
      cyc(1);
      chk({31'h0, unlock_limit}, 32'h1);
      lol_count = 8'hff;
      wr(IDX_REF_FB, 32'hf0);
      chk({28'h0, unlock_count_threshold}, 32'hf);
      chk({31'h0, unlock_limit}, 32'h1);
      lol_count = 8'h0f;
      cyc(1);
      chk({31'h0, unlock_limit}, 32'h0);
      rd(IDX_REF_FB, 32'hf0);
      wr(IDX_BANK_EN, 32'h0);
      chk(bank_mux_enables, 32'h0);
      wr(IDX_BANK_EN, 32'h80000000);
      rd(IDX_BANK_EN, 32'h80000000);
      wr(2'h2, 32'h12345678);
      rd(2'h2, 32'h0);
      chk(bank_mux_enables, 32'h80000000);
      // hardware takes over the input b gates of all three banks
      bank_auto_fanout = 3'h7;
      bank_fanout_mode = 9'h092;
      mux_uses_input_b = 3'h5;
      cyc(2);
      wr(IDX_BANK_EN, 32'h20000000);
      chk(bank_mux_enables, 32'h50000000);
      rd(IDX_BANK_EN, 32'h50000000);
      // then the input a gates
      bank_fanout_mode = 9'h049;
      mux_uses_input_a = 3'h2;
      cyc(2);
      wr(IDX_BANK_EN, 32'hffffffff);
      chk(bank_mux_enables, 32'hf5ffffff);
      rd(IDX_BANK_EN, 32'hf5ffffff);
      bank_auto_fanout = 3'h0;
      mux_uses_input_a = 3'h5;
      cyc(2);
      chk(bank_mux_enables, 32'hf5ffffff);
      wr(IDX_BANK_EN, 32'h0e000000);
      chk(bank_mux_enables, 32'h0e000000);
      // a second reset in mid-run restores every gate and field
      sys_rst = 1'b1;
      cyc(1);
      chk(bank_mux_enables, BANK_RESET);
      chk({30'h0, ref_select}, 32'h0);
      sys_rst = 1'b0;
      cyc(1);
      chk({31'h0, unlock_limit}, 32'h1);
      test_done();
   end
endmodule
